/* dv/downstream_model.sv */
// Model of the downstream receiver and authentication engine feeding the status block
`timescale 1ns/10ps
module downstream_model (
  // Clock
  input wire logic clk_in,
  // Receiver levels
  output logic receiver_irq_n_out,
  output logic sink_lock_out,
  output logic receiver_present_out,
  // Link and engine events
  output logic side_channel_error_out,
  output logic downstream_hotplug_out,
  output logic key_read_done_out,
  output logic list_read_done_out,
  output logic auth_success_out,
  output logic auth_lost_out
);
  // Idle link: interrupt pin released high, nothing detected, no events
  initial begin
    receiver_irq_n_out = 1'b1;
    sink_lock_out = 1'b0;
    receiver_present_out = 1'b0;
    {side_channel_error_out, downstream_hotplug_out, key_read_done_out} = 3'h0;
    {list_read_done_out, auth_success_out, auth_lost_out} = 3'h0;
  end

  // Levels change just after an edge
  task automatic set_levels(input logic irq_n, input logic lock, input logic present);
    @(posedge clk_in);
    receiver_irq_n_out <= irq_n;
    sink_lock_out <= lock;
    receiver_present_out <= present;
  endtask : set_levels

  // One-cycle event after a random gap, so answers come both promptly and late
  task automatic pulse(input int which, input int max_gap);
    repeat ($urandom_range(max_gap, 0)) @(posedge clk_in);
    @(posedge clk_in);
    case (which)
      0: side_channel_error_out <= 1'b1;
      1: downstream_hotplug_out <= 1'b1;
      2: key_read_done_out <= 1'b1;
      3: list_read_done_out <= 1'b1;
      4: auth_success_out <= 1'b1;
      default: auth_lost_out <= 1'b1;
    endcase
    @(posedge clk_in);
    {side_channel_error_out, downstream_hotplug_out, key_read_done_out} <= 3'h0;
    {list_read_done_out, auth_success_out, auth_lost_out} <= 3'h0;
  endtask : pulse
endmodule : downstream_model

/* dv/tb.sv */
// Self-checking bench for the link protection status register bank
`timescale 1ns/10ps
module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0_000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, running, proceed, irq, rd_err;
  logic irq_n, lock, present, err_ev, hp_ev, key_ev, list_ev, ok_ev, lost_ev;
  int compares = 0, miscompares = 0, proceeds = 0;

  // 125 MHz core clock
  initial begin
    forever #4 clk_in = ~clk_in;
  end

  downstream_model part_u (.clk_in(clk_in), .receiver_irq_n_out(irq_n),
    .sink_lock_out(lock), .receiver_present_out(present), .side_channel_error_out(err_ev),
    .downstream_hotplug_out(hp_ev), .key_read_done_out(key_ev),
    .list_read_done_out(list_ev), .auth_success_out(ok_ev), .auth_lost_out(lost_ev));

  link_protection_status_reg dut_u (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .side_channel_error_in(err_ev), .receiver_irq_input_pin_in(irq_n),
    .sink_lock_in(lock), .downstream_hotplug_in(hp_ev), .receiver_present_in(present),
    .key_read_done_in(key_ev), .list_read_done_in(list_ev), .auth_success_in(ok_ev),
    .auth_lost_in(lost_ev), .auth_running_out(running), .auth_proceed_out(proceed),
    .irq_out(irq));

  // Count engine release pulses, each one cycle long
  always @(posedge clk_in) begin
    if (proceed === 1'b1) proceeds <= proceeds + 1;
  end

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {a[9:0], 2'b00};
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_chk

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_in);
  endtask : ticks

  // Status image of the mirrored levels {irq_n, lock, present}
  function automatic logic [31:0] mirror(input logic [2:0] lv);
    return {24'h00_0000, 1'b0, lv[2], lv[1], 1'b0, lv[0], 3'h0};
  endfunction : mirror

  // Full authentication pass with all levels high (status base 0x68)
  task automatic run_auth(input logic rep);
    int p0;
    apb(1'b1, link_protection_pkg::config_offset, {31'h0, rep});
    apb(1'b1, link_protection_pkg::control_offset, 32'h0000_0001);
    rd_chk(link_protection_pkg::control_offset, 32'h0000_0001);
    part_u.pulse(2, 6);
    ticks(2);
    rd_chk(link_protection_pkg::status_offset, 32'h0000_006a);
    if (rep) begin
      part_u.pulse(3, 6);
      ticks(2);
      rd_chk(link_protection_pkg::status_offset, 32'h0000_006e);
    end
    p0 = proceeds;
    ticks(10);
    check(32'(proceeds), 32'(p0));
    apb(1'b1, link_protection_pkg::control_offset, rep ? 32'h0000_0020 : 32'h0000_0010);
    ticks(3);
    check(32'(proceeds), 32'(p0 + 1));
    rd_chk(link_protection_pkg::control_offset, 32'h0000_0001);
    rd_chk(link_protection_pkg::status_offset, 32'h0000_0068);
    part_u.pulse(4, 6);
    ticks(2);
    rd_chk(link_protection_pkg::status_offset, 32'h0000_0069);
    $display("test auth repeater=%0d done", rep);
  endtask : run_auth

  // Main sequence
  initial begin
    logic [2:0] lv;
    void'($urandom(32'h1121ed99));
    ticks(8);
    rst_in <= 1'b0;
    rd_chk(link_protection_pkg::status_offset, mirror(3'b100));
    rd_chk(link_protection_pkg::irq_mask_offset, 32'h0000_0000);
    $display("test reset done");
    // Random levels, with writes to the read-only status ignored
    for (int i = 0; i < 8; i++) begin
      lv = (i == 0) ? 3'b000 : (i == 1) ? 3'b111 : 3'($urandom);
      part_u.set_levels(lv[2], lv[1], lv[0]);
      apb(1'b1, link_protection_pkg::status_offset, 32'hffff_ffff);
      rd_chk(link_protection_pkg::status_offset, mirror(lv));
    end
    apb(1'b0, 12'h1_00, 32'h0000_0000);
    check({31'h0, rd_err}, 32'h0000_0001);
    $display("test levels done");
    // Clear on read, and an event landing during the read survives
    part_u.set_levels(1'b1, 1'b1, 1'b1);
    part_u.pulse(0, 3);
    part_u.pulse(1, 3);
    rd_chk(link_protection_pkg::status_offset, 32'h0000_00f8);
    rd_chk(link_protection_pkg::status_offset, 32'h0000_0068);
    fork
      apb(1'b0, link_protection_pkg::status_offset, 32'h0000_0000);
      begin
        @(posedge clk_in);
        part_u.pulse(0, 0);
      end
    join
    check(rd, 32'h0000_0068);
    rd_chk(link_protection_pkg::status_offset, 32'h0000_00e8);
    $display("test clear on read done");
    // Interrupt raise, mask and clear
    apb(1'b1, link_protection_pkg::irq_status_offset, 32'h0000_001f);
    rd_chk(link_protection_pkg::irq_status_offset, 32'h0000_0000);
    apb(1'b1, link_protection_pkg::irq_mask_offset, 32'h0000_0003);
    part_u.pulse(0, 0);
    ticks(3);
    check({31'h0, irq}, 32'h0000_0001);
    rd_chk(link_protection_pkg::irq_status_offset, 32'h0000_0001);
    apb(1'b1, link_protection_pkg::irq_status_offset, 32'h0000_0001);
    ticks(2);
    check({31'h0, irq}, 32'h0000_0000);
    part_u.pulse(1, 0);
    ticks(3);
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, link_protection_pkg::irq_mask_offset, 32'h0000_0000);
    ticks(2);
    check({31'h0, irq}, 32'h0000_0000);
    rd_chk(link_protection_pkg::status_offset, 32'h0000_0078);
    rd_chk(link_protection_pkg::irq_status_offset, 32'h0000_0000);
    $display("test interrupt done");
    // Authentication, loss, restart and a start write of zero
    run_auth(1'b0);
    part_u.pulse(5, 0);
    ticks(2);
    rd_chk(link_protection_pkg::status_offset, 32'h0000_0068);
    run_auth(1'b1);
    apb(1'b1, link_protection_pkg::control_offset, 32'h0000_0001);
    rd_chk(link_protection_pkg::status_offset, 32'h0000_0068);
    apb(1'b1, link_protection_pkg::control_offset, 32'h0000_0000);
    check({31'h0, running}, 32'h0000_0001);
    $display("test restart done");
    stop_test();
  end
endmodule : tb

/* logic/event_flag_if.sv */
// Interface: sticky event flags between the status core and the event latch
`timescale 1ns/10ps
interface event_flag_if;
  logic [4:0] event_set;
  logic [4:0] event_clear;
  logic [4:0] event_flags;
  modport core (output event_set, output event_clear, input event_flags);
  modport latch (input event_set, input event_clear, output event_flags);
endinterface : event_flag_if

/* logic/event_flag_latch.sv */
// Sticky event flags with set-over-clear priority
`timescale 1ns/10ps
module event_flag_latch (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Flag port
  event_flag_if.latch flags
);
  typedef struct packed {
    logic [4:0] flag;
  } latch_state_type;

  latch_state_type state;
  latch_state_type next_state;

  // Set wins so an event landing on a clear is kept
  always_comb begin
    next_state = state;
    next_state.flag = (state.flag & ~flags.event_clear) | flags.event_set;
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags.event_flags = state.flag;

  property p_set_wins;
    @(posedge clk_in) disable iff (rst_in)
    |flags.event_set |=> ((state.flag & $past(flags.event_set)) == $past(flags.event_set));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");
endmodule : event_flag_latch

/* logic/link_protection_pkg.sv */
// Package: register map, field positions and reset values for the link protection status block
package link_protection_pkg;
  // Register indices; one word each, so the byte address is four times the index
  localparam logic [11:0] status_offset = 12'h0_0c4;
  localparam logic [11:0] control_offset = 12'h0_0c3;
  localparam logic [11:0] irq_status_offset = 12'h0_0d0;
  localparam logic [11:0] irq_mask_offset = 12'h0_0d4;
  localparam logic [11:0] config_offset = 12'h0_0d8;
  // Status field positions
  localparam int side_channel_error_pos = 7;
  localparam int receiver_irq_pos = 6;
  localparam int sink_lock_pos = 5;
  localparam int downstream_hotplug_pos = 4;
  localparam int receiver_present_pos = 3;
  localparam int key_list_ready_pos = 2;
  localparam int receiver_key_ready_pos = 1;
  localparam int authentication_done_pos = 0;
  // Control field positions
  localparam int protection_start_pos = 0;
  localparam int receiver_key_accepted_pos = 4;
  localparam int key_list_accepted_pos = 5;
  // Config field positions
  localparam int repeater_mode_pos = 0;
  // Interrupt event positions
  localparam int irq_error_pos = 0;
  localparam int irq_hotplug_pos = 1;
  localparam int irq_list_ready_pos = 2;
  localparam int irq_key_ready_pos = 3;
  localparam int irq_auth_pos = 4;
  // Reset values
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [4:0] irq_mask_reset = 5'h00;
  localparam logic repeater_mode_reset = 1'b0;
  // Engine states
  typedef enum logic [4:0] {
    st_idle = 5'b0_0001,
    st_wait_key = 5'b0_0010,
    st_wait_list = 5'b0_0100,
    st_finish = 5'b0_1000,
    st_done = 5'b1_0000
  } engine_state_type;
endpackage : link_protection_pkg

/* logic/link_protection_status_reg.sv */
// Link protection status register bank with APB slave and event interrupt
// Functional notes
// - Bit 7 sets on a side-channel error and clears when the status register is read.
// - Bit 6 mirrors the receiver's active-low interrupt pin, so 0 means interrupt pending.
// - Bit 5 is high while the receiver reports lock to the serial stream.
// - Bit 4 sets on a downstream hot-plug report and clears when the status register is read.
// - Bit 3 is high while a downstream receiver is detected.
// - In repeater mode bit 2 sets once the key list sits in the list buffer.
// - After list ready the engine waits for list-valid, whose write clears list ready.
// - Bit 1 sets once the receiver key is in the receiver key registers.
// - Outside repeater mode the engine holds after key ready until key-valid clears it.
// - Bit 0 sets when authentication completes successfully.
// - Bit 0 clears when authentication is lost or the host restarts it.
// - Writing 1 to the start bit starts or restarts authentication; writing 0 does nothing.
// - The list-valid bit clears itself after it has been acted on.
`timescale 1ns/10ps
module link_protection_status_reg (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Downstream link conditions
  input wire logic side_channel_error_in,
  input wire logic receiver_irq_input_pin_in,
  input wire logic sink_lock_in,
  input wire logic downstream_hotplug_in,
  input wire logic receiver_present_in,
  // Authentication engine conditions
  input wire logic key_read_done_in,
  input wire logic list_read_done_in,
  input wire logic auth_success_in,
  input wire logic auth_lost_in,
  // Engine control and interrupt
  output logic auth_running_out,
  output logic auth_proceed_out,
  output logic irq_out
);
  typedef struct packed {
    link_protection_pkg::engine_state_type engine;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic receiver_irq;
    logic sink_lock;
    logic receiver_present;
    logic key_list_ready_flag;
    logic receiver_key_ready_flag;
    logic authentication_done_flag;
    logic enabled;
    logic key_list_accepted_bit;
    logic receiver_key_accepted_bit;
    logic repeater_mode;
    logic [4:0] irq_mask;
    logic irq;
    logic proceed;
  } core_state_type;

  core_state_type state;
  core_state_type next_state;
  event_flag_if flags ();

  logic access;
  logic wr;
  logic rd;
  logic [7:0] status_view;
  logic [4:0] next_event_set;
  logic [4:0] next_event_clear;

  // Word decode shared by read and write paths
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] offset);
    // Offsets are word indices, so the byte address drops its two low bits
    hit = (addr[11:2] == offset[9:0]);
  endfunction : hit

  event_flag_latch u_events (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flags(flags)
  );

  // APB access phase; slave answers in one wait cycle, so pready rises on the second edge
  assign access = psel_in & penable_in & ~state.ready;
  assign wr = access & pwrite_in;
  assign rd = access & ~pwrite_in;

  // Assembled status byte as software sees it
  always_comb begin
    status_view = link_protection_pkg::status_reset;
    status_view[link_protection_pkg::side_channel_error_pos] =
      flags.event_flags[link_protection_pkg::irq_error_pos];
    status_view[link_protection_pkg::receiver_irq_pos] = state.receiver_irq;
    status_view[link_protection_pkg::sink_lock_pos] = state.sink_lock;
    status_view[link_protection_pkg::downstream_hotplug_pos] =
      flags.event_flags[link_protection_pkg::irq_hotplug_pos];
    status_view[link_protection_pkg::receiver_present_pos] = state.receiver_present;
    status_view[link_protection_pkg::key_list_ready_pos] = state.key_list_ready_flag;
    status_view[link_protection_pkg::receiver_key_ready_pos] = state.receiver_key_ready_flag;
    status_view[link_protection_pkg::authentication_done_pos] = state.authentication_done_flag;
  end

  // Event sets and write-one or read clears toward the sticky latch
  always_comb begin
    next_event_set = '0;
    next_event_clear = '0;
    next_event_set[link_protection_pkg::irq_error_pos] = side_channel_error_in;
    next_event_set[link_protection_pkg::irq_hotplug_pos] = downstream_hotplug_in;
    next_event_set[link_protection_pkg::irq_list_ready_pos] =
      list_read_done_in & (state.engine == link_protection_pkg::st_wait_list);
    next_event_set[link_protection_pkg::irq_key_ready_pos] =
      key_read_done_in & (state.engine == link_protection_pkg::st_wait_key);
    next_event_set[link_protection_pkg::irq_auth_pos] =
      auth_success_in & (state.engine == link_protection_pkg::st_finish);
    if (rd && hit(paddr_in, link_protection_pkg::status_offset)) begin
      // Clear lands after the read data are captured; latch lets a same-cycle set win
      next_event_clear[link_protection_pkg::irq_error_pos] = 1'b1;
      next_event_clear[link_protection_pkg::irq_hotplug_pos] = 1'b1;
    end
    if (wr && hit(paddr_in, link_protection_pkg::irq_status_offset)) begin
      // Every event bit is write-one-to-clear, including the two that a status read clears
      next_event_clear[link_protection_pkg::irq_error_pos] =
        pwdata_in[link_protection_pkg::irq_error_pos];
      next_event_clear[link_protection_pkg::irq_hotplug_pos] =
        pwdata_in[link_protection_pkg::irq_hotplug_pos];
      next_event_clear[link_protection_pkg::irq_list_ready_pos] =
        pwdata_in[link_protection_pkg::irq_list_ready_pos];
      next_event_clear[link_protection_pkg::irq_key_ready_pos] =
        pwdata_in[link_protection_pkg::irq_key_ready_pos];
      next_event_clear[link_protection_pkg::irq_auth_pos] =
        pwdata_in[link_protection_pkg::irq_auth_pos];
    end
  end

  assign flags.event_set = next_event_set;
  assign flags.event_clear = next_event_clear;

  // Main next-state logic: bus, level mirrors, authentication handshake
  always_comb begin
    next_state = state;
    next_state.ready = access;
    next_state.slverr = 1'b0;
    next_state.rdata = '0;
    next_state.receiver_irq = receiver_irq_input_pin_in;
    next_state.sink_lock = sink_lock_in;
    next_state.receiver_present = receiver_present_in;
    next_state.key_list_accepted_bit = 1'b0;
    next_state.receiver_key_accepted_bit = 1'b0;
    next_state.proceed = 1'b0;
    if (rd) begin
      // Read data reflect pre-read flag values
      if (hit(paddr_in, link_protection_pkg::status_offset)) begin
        next_state.rdata = {24'h00_0000, status_view};
      end else if (hit(paddr_in, link_protection_pkg::control_offset)) begin
        next_state.rdata[link_protection_pkg::protection_start_pos] = state.enabled;
      end else if (hit(paddr_in, link_protection_pkg::irq_status_offset)) begin
        next_state.rdata = {27'h000_0000, flags.event_flags};
      end else if (hit(paddr_in, link_protection_pkg::irq_mask_offset)) begin
        next_state.rdata = {27'h000_0000, state.irq_mask};
      end else if (hit(paddr_in, link_protection_pkg::config_offset)) begin
        next_state.rdata[link_protection_pkg::repeater_mode_pos] = state.repeater_mode;
      end else begin
        next_state.slverr = 1'b1;
      end
    end
    if (wr) begin
      if (hit(paddr_in, link_protection_pkg::control_offset)) begin
        if (pwdata_in[link_protection_pkg::protection_start_pos]) begin
          next_state.enabled = 1'b1;
        end
        next_state.key_list_accepted_bit = pwdata_in[link_protection_pkg::key_list_accepted_pos];
        next_state.receiver_key_accepted_bit =
          pwdata_in[link_protection_pkg::receiver_key_accepted_pos];
      end else if (hit(paddr_in, link_protection_pkg::irq_mask_offset)) begin
        next_state.irq_mask = pwdata_in[4:0];
      end else if (hit(paddr_in, link_protection_pkg::config_offset)) begin
        next_state.repeater_mode = pwdata_in[link_protection_pkg::repeater_mode_pos];
      end else if (!hit(paddr_in, link_protection_pkg::irq_status_offset) &&
                   !hit(paddr_in, link_protection_pkg::status_offset)) begin
        next_state.slverr = 1'b1;
      end
    end
    // Authentication sequence, acting on last cycle's accepted bits
    unique case (state.engine)
      link_protection_pkg::st_idle: begin
        if (state.enabled) begin
          next_state.engine = link_protection_pkg::st_wait_key;
        end
      end
      link_protection_pkg::st_wait_key: begin
        if (state.receiver_key_ready_flag) begin
          if (state.repeater_mode) begin
            next_state.engine = link_protection_pkg::st_wait_list;
          end else if (state.receiver_key_accepted_bit) begin
            next_state.receiver_key_ready_flag = 1'b0;
            next_state.proceed = 1'b1;
            next_state.engine = link_protection_pkg::st_finish;
          end
        end else if (key_read_done_in) begin
          next_state.receiver_key_ready_flag = 1'b1;
        end
      end
      link_protection_pkg::st_wait_list: begin
        if (state.key_list_ready_flag) begin
          if (state.key_list_accepted_bit) begin
            next_state.key_list_ready_flag = 1'b0;
            next_state.proceed = 1'b1;
            next_state.engine = link_protection_pkg::st_finish;
          end
        end else if (list_read_done_in) begin
          next_state.key_list_ready_flag = 1'b1;
        end
      end
      link_protection_pkg::st_finish: begin
        if (auth_success_in) begin
          next_state.authentication_done_flag = 1'b1;
          next_state.engine = link_protection_pkg::st_done;
        end
      end
      link_protection_pkg::st_done: begin
        next_state.engine = link_protection_pkg::st_done;
      end
      default: begin
        next_state.engine = link_protection_pkg::st_idle;
      end
    endcase
    // Repeater key flag is cleared by list-valid as well, since no key-valid wait applies
    if (state.repeater_mode && state.key_list_accepted_bit) begin
      next_state.receiver_key_ready_flag = 1'b0;
    end
    // Loss or restart drops authentication and rewinds the sequence
    if (auth_lost_in ||
        (wr && hit(paddr_in, link_protection_pkg::control_offset) &&
         pwdata_in[link_protection_pkg::protection_start_pos])) begin
      next_state.authentication_done_flag = 1'b0;
      next_state.key_list_ready_flag = 1'b0;
      next_state.receiver_key_ready_flag = 1'b0;
      next_state.engine = link_protection_pkg::st_idle;
    end
    next_state.irq = |(flags.event_flags & state.irq_mask);
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= '0;
      state.engine <= link_protection_pkg::st_idle;
      state.receiver_irq <= 1'b1;
      state.irq_mask <= link_protection_pkg::irq_mask_reset;
      state.repeater_mode <= link_protection_pkg::repeater_mode_reset;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_out = state.rdata;
  assign pready_out = state.ready;
  assign pslverr_out = state.slverr;
  assign auth_running_out = state.enabled;
  assign auth_proceed_out = state.proceed;
  assign irq_out = state.irq;

  property p_receiver_irq_mirror;
    @(posedge clk_in) disable iff (rst_in)
    ##1 state.receiver_irq == $past(receiver_irq_input_pin_in);
  endproperty
  a_receiver_irq_mirror: assert property (p_receiver_irq_mirror) else $error("irq mirror");

  property p_lock_mirror;
    @(posedge clk_in) disable iff (rst_in)
    sink_lock_in |=> state.sink_lock;
  endproperty
  a_lock_mirror: assert property (p_lock_mirror) else $error("lock mirror");

  property p_present_mirror;
    @(posedge clk_in) disable iff (rst_in)
    !receiver_present_in |=> !state.receiver_present;
  endproperty
  a_present_mirror: assert property (p_present_mirror) else $error("presence mirror");

  property p_error_read_clear;
    @(posedge clk_in) disable iff (rst_in)
    rd && hit(paddr_in, link_protection_pkg::status_offset) && !side_channel_error_in
    |=> !flags.event_flags[link_protection_pkg::irq_error_pos];
  endproperty
  a_error_read_clear: assert property (p_error_read_clear) else $error("error not cleared");

  property p_hotplug_set;
    @(posedge clk_in) disable iff (rst_in)
    downstream_hotplug_in |=> flags.event_flags[link_protection_pkg::irq_hotplug_pos];
  endproperty
  a_hotplug_set: assert property (p_hotplug_set) else $error("hotplug lost");

  property p_read_snapshot;
    @(posedge clk_in) disable iff (rst_in)
    rd && hit(paddr_in, link_protection_pkg::status_offset)
    |=> prdata_out[7:0] == $past(status_view) && pready_out;
  endproperty
  a_read_snapshot: assert property (p_read_snapshot) else $error("read not pre-clear");

  sequence s_list_waiting;
    state.engine == link_protection_pkg::st_wait_list && state.key_list_ready_flag;
  endsequence
  property p_list_handshake;
    @(posedge clk_in) disable iff (rst_in)
    s_list_waiting ##0 (!state.key_list_accepted_bit && !auth_lost_in &&
      !(wr && hit(paddr_in, link_protection_pkg::control_offset) &&
        pwdata_in[link_protection_pkg::protection_start_pos]))
    |=> state.key_list_ready_flag;
  endproperty
  a_list_handshake: assert property (p_list_handshake) else $error("list wait broken");

  property p_key_hold;
    @(posedge clk_in) disable iff (rst_in)
    state.engine == link_protection_pkg::st_wait_key && state.receiver_key_ready_flag &&
    !state.repeater_mode && !state.receiver_key_accepted_bit |=> !state.proceed;
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("key wait broken");

  property p_auth_lost;
    @(posedge clk_in) disable iff (rst_in)
    auth_lost_in |=> !state.authentication_done_flag;
  endproperty
  a_auth_lost: assert property (p_auth_lost) else $error("auth not dropped");

  property p_list_self_clear;
    @(posedge clk_in) disable iff (rst_in)
    state.key_list_accepted_bit && !wr |=> !state.key_list_accepted_bit;
  endproperty
  a_list_self_clear: assert property (p_list_self_clear) else $error("list bit stuck");
endmodule : link_protection_status_reg
